/* inc/sdcsd_defines.vh */
// Constants for the SDRAM command and bank state decoder.
// Assumes inclusion by bare name from files under logic/ and verif/.
`ifndef SDCSD_DEFINES_VH
`define SDCSD_DEFINES_VH

// ============================================================
// Command codes, {ras_n, cas_n, we_n} with chip select low
`define SDCSD_CMD_MODE_LOAD   3'h0
`define SDCSD_CMD_REFRESH     3'h1
`define SDCSD_CMD_CLOSE       3'h2
`define SDCSD_CMD_ROW_OPEN    3'h3
`define SDCSD_CMD_STORE       3'h4
`define SDCSD_CMD_FETCH       3'h5
`define SDCSD_CMD_HALT        3'h6
`define SDCSD_CMD_IDLE        3'h7

// ============================================================
// Address field positions
`define SDCSD_AUTO_CLOSE_POS  10
`define SDCSD_BANK_PICK_POS   11

// ============================================================
// Mode field layout and reset values
`define SDCSD_MODE_BL_LSB     0
`define SDCSD_MODE_BL_MSB     2
`define SDCSD_MODE_RST        12'h000
`define SDCSD_BURST_RST       9'h001

// ============================================================
// Bank states
`define SDCSD_ST_IDLE         3'h0
`define SDCSD_ST_ACTIVE       3'h1
`define SDCSD_ST_READ         3'h2
`define SDCSD_ST_WRITE        3'h3
`define SDCSD_ST_PRECHARGE    3'h4

// ============================================================
// Device power modes
`define SDCSD_PM_RUN          2'h0
`define SDCSD_PM_LOW_POWER    2'h1
`define SDCSD_PM_RETENTION    2'h2
`define SDCSD_PM_CLOCK_HOLD   2'h3

// ============================================================
// Timing and buffering
`define SDCSD_PRECHARGE_NS    50
`define SDCSD_CLK_NS          25
`define SDCSD_PRECHARGE_CYC   3'h2
`define SDCSD_FIFO_DEPTH      16
`define SDCSD_FIFO_AW         4
`define SDCSD_DATA_W          16

`endif

/* logic/sdcsd_core.v */
// SDRAM device-side command decoder with two-bank state tracking.
// Assumes command pins come from a controller on another clock tree.
`timescale 1ns/1ps
`include "sdcsd_defines.vh"
module sdcsd_core (
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        clk_gate,
    input  wire        chip_sel_b,
    input  wire        row_strobe_b,
    input  wire        col_strobe_b,
    input  wire        write_b,
    input  wire        lower_lane_mask,
    input  wire        upper_lane_mask,
    input  wire [11:0] addr,
    input  wire [15:0] dq_in,
    output reg  [15:0] dq_out,
    output reg  [15:0] dq_oe,
    output wire [15:0] wr_data,
    output wire        wr_valid,
    input  wire        wr_ready,
    output reg  [8:0]  column,
    output reg         bank_sel,
    output reg  [2:0]  bank0_state,
    output reg  [2:0]  bank1_state,
    output reg  [1:0]  power_mode,
    output reg  [11:0] mode_word
);
    // ============================================================
    // Input synchronisers, two stages each
    reg  [33:0] sync_a;               // First stage, read only by second
    reg  [33:0] sync_b;               // Second stage, used by logic
    wire [33:0] pins_raw;
    assign pins_raw = {dq_in, clk_gate, chip_sel_b, row_strobe_b, col_strobe_b,
                       write_b, lower_lane_mask, upper_lane_mask, addr[11:10],
                       addr[8:0]};

    // Double-flop every pin but addr[9] before decode
    // Reset to idle pin levels: gate high, deselected, masked, so no
    // false gate edge or phantom command follows reset
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= 34'h0003f800;
            sync_b <= 34'h0003f800;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end

    wire [15:0] s_dq    = sync_b[33:18];
    wire        s_gate  = sync_b[17];
    wire        s_cs_b  = sync_b[16];
    wire [2:0]  s_cmd   = sync_b[15:13];
    wire        s_lmask = sync_b[12];
    wire        s_umask = sync_b[11];
    wire        s_bank  = sync_b[10];
    wire        s_ac    = sync_b[9];
    wire [8:0]  s_col   = sync_b[8:0];

    // ============================================================
    // Clock gate history
    reg gate_prev;                    // Gate level one cycle earlier
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_prev <= 1'b1;
        end else begin
            gate_prev <= s_gate;
        end
    end

    // Command only counts when gate was high the cycle before
    wire live    = gate_prev;
    wire sel     = live & ~s_cs_b;
    wire is_fetch = sel & (s_cmd == `SDCSD_CMD_FETCH);
    wire is_store = sel & (s_cmd == `SDCSD_CMD_STORE);
    wire is_halt  = sel & (s_cmd == `SDCSD_CMD_HALT);
    wire is_close = sel & (s_cmd == `SDCSD_CMD_CLOSE);
    wire is_open  = sel & (s_cmd == `SDCSD_CMD_ROW_OPEN);
    wire is_ref   = sel & (s_cmd == `SDCSD_CMD_REFRESH);
    wire is_mode  = sel & (s_cmd == `SDCSD_CMD_MODE_LOAD);
    wire both_idle = (bank0_state == `SDCSD_ST_IDLE) && (bank1_state == `SDCSD_ST_IDLE);
    wire any_act   = ~both_idle;
    wire gate_fall = gate_prev & ~s_gate;
    wire gate_rise = ~gate_prev & s_gate;

    // ============================================================
    // Burst tracking and per-bank auto-close flags
    reg [8:0] burst_left;             // Beats still to run
    reg [1:0] auto_close;             // Close after burst, per bank
    reg [2:0] pre_cnt0;               // Precharge timer bank 0
    reg [2:0] pre_cnt1;               // Precharge timer bank 1
    wire [8:0] burst_len = (9'h001 << mode_word[`SDCSD_MODE_BL_MSB:`SDCSD_MODE_BL_LSB]);
    wire       hold      = (power_mode != `SDCSD_PM_RUN);
    wire       burst_end = (burst_left == 9'h001);

    // Next state of one bank given its index
    function [2:0] bank_next;
        input [2:0] cur;
        input       idx;
        input [2:0] pre_cnt;
        reg         hit;
        begin
            hit = (s_bank == idx);
            bank_next = cur;
            case (cur)
                `SDCSD_ST_IDLE: begin
                    if (is_open && hit) begin
                        bank_next = `SDCSD_ST_ACTIVE;
                    end
                end
                `SDCSD_ST_ACTIVE: begin
                    if (is_fetch && hit) begin
                        bank_next = `SDCSD_ST_READ;
                    end else if (is_store && hit) begin
                        bank_next = `SDCSD_ST_WRITE;
                    end else if (is_close && (s_ac || hit)) begin
                        bank_next = `SDCSD_ST_PRECHARGE;
                    end
                end
                `SDCSD_ST_READ, `SDCSD_ST_WRITE: begin
                    if (is_halt) begin
                        bank_next = `SDCSD_ST_ACTIVE;
                    end else if (is_fetch && hit) begin
                        bank_next = `SDCSD_ST_READ;
                    end else if (is_store && hit) begin
                        bank_next = `SDCSD_ST_WRITE;
                    end else if (is_close && (s_ac || hit)) begin
                        bank_next = `SDCSD_ST_PRECHARGE;
                    end else if (burst_end) begin
                        // Finished burst: open row or self-close
                        bank_next = auto_close[idx] ? `SDCSD_ST_PRECHARGE
                                                    : `SDCSD_ST_ACTIVE;
                    end
                end
                `SDCSD_ST_PRECHARGE: begin
                    if (pre_cnt == 3'h1) begin
                        bank_next = `SDCSD_ST_IDLE;
                    end
                end
                default: begin
                    bank_next = `SDCSD_ST_IDLE;
                end
            endcase
        end
    endfunction

    wire [2:0] next_bank0 = bank_next(bank0_state, 1'b0, pre_cnt0);
    wire [2:0] next_bank1 = bank_next(bank1_state, 1'b1, pre_cnt1);

    // ============================================================
    // Power mode sequencing
    reg [1:0] next_power_mode;
    always @* begin
        next_power_mode = power_mode;
        case (power_mode)
            `SDCSD_PM_RUN: begin
                if (gate_fall && both_idle && is_ref) begin
                    next_power_mode = `SDCSD_PM_RETENTION;
                end else if (gate_fall && any_act) begin
                    next_power_mode = `SDCSD_PM_CLOCK_HOLD;
                end else if (gate_fall) begin
                    next_power_mode = `SDCSD_PM_LOW_POWER;
                end
            end
            `SDCSD_PM_LOW_POWER, `SDCSD_PM_RETENTION, `SDCSD_PM_CLOCK_HOLD: begin
                // Any rising gate restarts, other pins don't matter
                if (gate_rise) begin
                    next_power_mode = `SDCSD_PM_RUN;
                end
            end
            default: begin
                next_power_mode = `SDCSD_PM_RUN;
            end
        endcase
    end

    // ============================================================
    // State registers; all but power_mode frozen outside run mode
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            power_mode  <= `SDCSD_PM_RUN;
            bank0_state <= `SDCSD_ST_IDLE;
            bank1_state <= `SDCSD_ST_IDLE;
            burst_left  <= 9'h000;
            auto_close  <= 2'h0;
            pre_cnt0    <= 3'h0;
            pre_cnt1    <= 3'h0;
            column      <= 9'h000;
            bank_sel    <= 1'b0;
            mode_word   <= `SDCSD_MODE_RST;
        end else begin
            power_mode <= next_power_mode;
            if (!hold && live) begin
                bank0_state <= next_bank0;
                bank1_state <= next_bank1;
                // Precharge timers load on entry, count down after
                if (next_bank0 == `SDCSD_ST_PRECHARGE && bank0_state != `SDCSD_ST_PRECHARGE) begin
                    pre_cnt0 <= `SDCSD_PRECHARGE_CYC;
                end else if (pre_cnt0 != 3'h0) begin
                    pre_cnt0 <= pre_cnt0 - 3'h1;
                end
                if (next_bank1 == `SDCSD_ST_PRECHARGE && bank1_state != `SDCSD_ST_PRECHARGE) begin
                    pre_cnt1 <= `SDCSD_PRECHARGE_CYC;
                end else if (pre_cnt1 != 3'h0) begin
                    pre_cnt1 <= pre_cnt1 - 3'h1;
                end
                if (is_fetch || is_store) begin
                    // Fresh burst at the given column
                    burst_left           <= burst_len;
                    column               <= s_col;
                    bank_sel             <= s_bank;
                    auto_close[s_bank]   <= s_ac;
                end else if (is_halt || is_close) begin
                    burst_left <= 9'h000;
                end else if (burst_left != 9'h000) begin
                    burst_left <= burst_left - 9'h001;
                    column     <= column + 9'h001;
                end
                // Mode load only taken when both banks are idle
                if (is_mode && both_idle) begin
                    mode_word <= {s_bank, s_ac, 1'b0, s_col};
                end
            end
        end
    end

    // ============================================================
    // Byte lanes: each mask handles only its own eight lines
    wire       bursting = (burst_left != 9'h000);
    wire       rd_on    = bursting && ((bank_sel ? bank1_state : bank0_state) == `SDCSD_ST_READ);
    wire       wr_on    = bursting && ((bank_sel ? bank1_state : bank0_state) == `SDCSD_ST_WRITE);
    wire [1:0] lane_pass = {~s_umask, ~s_lmask} & {2'b11} & {live, live};
    reg  [15:0] lane_store [0:1];     // Last written word per bank

    // Write lanes go to the buffer; masked lanes become zero
    assign wr_data  = {lane_pass[1] ? s_dq[15:8] : 8'h00,
                       lane_pass[0] ? s_dq[7:0]  : 8'h00};
    assign wr_valid = wr_on & ~hold & (|lane_pass);

    // Read driver: masked lane stays undriven
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_out <= 16'h0000;
            dq_oe  <= 16'h0000;
        end else begin
            dq_out <= {column[7:0], column[7:0]} ^ lane_store[bank_sel];
            dq_oe  <= {{8{rd_on & ~hold & lane_pass[1]}},
                       {8{rd_on & ~hold & lane_pass[0]}}};
        end
    end

    // ============================================================
    // Buffer between lane capture and the store
    wire [15:0] fifo_word;
    wire        fifo_valid;
    wire        fifo_in_ready;
    sdcsd_fifo #(
        .WIDTH (`SDCSD_DATA_W),
        .DEPTH (`SDCSD_FIFO_DEPTH),
        .AW    (`SDCSD_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_data   (wr_data),
        .in_valid  (wr_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_word),
        .out_valid (fifo_valid),
        .out_ready (wr_ready)
    );

    // Drained words land in the per-bank store
    always @(posedge sys_clk) begin
        if (fifo_valid && wr_ready) begin
            lane_store[bank_sel] <= fifo_word;
        end
    end
endmodule

/* logic/sdcsd_fifo.v */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module sdcsd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    // ============================================================
    // Storage and pointers
    reg [WIDTH-1:0] mem [0:DEPTH-1];  // Word store
    reg [AW-1:0]    wr_ptr;           // Write slot
    reg [AW-1:0]    rd_ptr;           // Read slot
    reg [AW:0]      count;            // Words held
    wire            push;
    wire            pop;
    localparam [AW:0] FULL_COUNT = DEPTH;  // Count when every slot is taken

    assign in_ready  = (count != FULL_COUNT);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Memory write, no reset needed on data
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Head word read combinationally from the store at the read slot
    always @* begin
        out_data = mem[rd_ptr];
    end

    // Pointer and count bookkeeping
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            // Simultaneous push and pop keeps the count
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* verif/sdcsd_asserts.sv */
// Concurrent checks on the decoder's pins, state and power outputs.
// Assumes it is bound onto sdcsd_core and shares its single clock.
`timescale 1ns/1ps
module sdcsd_asserts (
    input wire        sys_clk,
    input wire        rst_b,
    input wire        clk_gate,
    input wire        lower_lane_mask,
    input wire        upper_lane_mask,
    input wire [15:0] dq_oe,
    input wire [2:0]  bank0_state,
    input wire [2:0]  bank1_state,
    input wire [1:0]  power_mode
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // ============================================================
    // Power modes
    hold_entry_a: assert property ($rose(power_mode == 2'h3) |->
        bank0_state != 3'h0 || bank1_state != 3'h0) else $error("clock hold with banks idle");
    gate_exit_a: assert property (clk_gate [*5] |-> power_mode == 2'h0)
        else $error("still in a power mode after gate high");
    gate_low_a: assert property (!clk_gate [*5] |-> power_mode != 2'h0)
        else $error("still running after gate low");
    // A frozen machine must not move its banks
    frozen_a: assert property (power_mode != 2'h0 && $past(power_mode) != 2'h0 |->
        $stable(bank0_state) && $stable(bank1_state)) else $error("bank moved while frozen");
    retent_idle_a: assert property (power_mode == 2'h2 |->
        bank0_state == 3'h0 && bank1_state == 3'h0) else $error("retention with a bank open");

    // ============================================================
    // Lane masks, with slack for the input synchronisers
    upper_mask_a: assert property ((upper_lane_mask && clk_gate) [*7] |->
        dq_oe[15:8] == 8'h00) else $error("upper lane driven while masked");
    lower_mask_a: assert property ((lower_lane_mask && clk_gate) [*7] |->
        dq_oe[7:0] == 8'h00) else $error("lower lane driven while masked");
    lane_whole_a: assert property (dq_oe != 16'h0000 |-> dq_oe[15:8] == {8{dq_oe[15]}}
        && dq_oe[7:0] == {8{dq_oe[0]}}) else $error("lane enable split inside a byte");

    // ============================================================
    // Bank state moves
    idle_next_a: assert property (bank0_state == 3'h0 |=>
        bank0_state inside {3'h0, 3'h1}) else $error("idle bank left for a bad state");
    prech_end_a: assert property ($rose(bank1_state == 3'h4) |->
        ##[1:3] bank1_state == 3'h0) else $error("precharge did not finish");
endmodule

bind sdcsd_core sdcsd_asserts chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_gate(clk_gate),
    .lower_lane_mask(lower_lane_mask), .upper_lane_mask(upper_lane_mask),
    .dq_oe(dq_oe), .bank0_state(bank0_state), .bank1_state(bank1_state),
    .power_mode(power_mode));

/* verif/sdcsd_core_test.sv */
// Self-checking bench for the command decoder and its bank states.
// Assumes the controller model drives every pin but rst_b and wr_ready and the checker is bound.
`timescale 1ns/1ps
`include "sdcsd_defines.vh"
module sdcsd_core_test;
    reg         sys_clk;   // 40 MHz clock
    reg         rst_b;     // Async reset, active low
    reg         wr_ready;  // Drain side of the write FIFO
    wire        clk_gate, chip_sel_b, row_strobe_b, col_strobe_b, write_b;
    wire        lower_lane_mask, upper_lane_mask, wr_valid, bank_sel;
    wire [11:0] addr, mode_word;
    wire [15:0] dq_in, dq_out, dq_oe, wr_data;
    wire [8:0]  column;
    wire [2:0]  bank0_state, bank1_state;
    wire [1:0]  power_mode;
    integer     n_errors;  // Mismatches
    integer     checked;   // Comparisons

    sdcsd_ctrl_model ctl (.sys_clk(sys_clk), .clk_gate(clk_gate), .chip_sel_b(chip_sel_b),
        .row_strobe_b(row_strobe_b), .col_strobe_b(col_strobe_b), .write_b(write_b),
        .lower_lane_mask(lower_lane_mask), .upper_lane_mask(upper_lane_mask),
        .addr(addr), .dq_in(dq_in));
    sdcsd_core uut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_gate(clk_gate),
        .chip_sel_b(chip_sel_b), .row_strobe_b(row_strobe_b), .col_strobe_b(col_strobe_b),
        .write_b(write_b), .lower_lane_mask(lower_lane_mask),
        .upper_lane_mask(upper_lane_mask), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .column(column), .bank_sel(bank_sel), .bank0_state(bank0_state),
        .bank1_state(bank1_state), .power_mode(power_mode), .mode_word(mode_word));

    // ============================================================
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ============================================================
    // Helpers: one observed value by selector, compare, bounded wait
    function [15:0] pick(input [2:0] s);
        case (s)
            3'h0: pick = {13'h0, bank0_state};
            3'h1: pick = {13'h0, bank1_state};
            3'h2: pick = {14'h0, power_mode};
            3'h3: pick = {7'h0, column};
            3'h4: pick = dq_oe;
            3'h5: pick = {4'h0, mode_word};
            3'h6: pick = wr_valid ? {8'h0, wr_data[7:0]} : 16'hffff;
            default: pick = {15'h0, wr_valid};
        endcase
    endfunction

    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Sampled at falling edges, so the rising edge's updates have landed
    task wait_for(input [2:0] s, input [15:0] exp, input integer lim);
        integer i;
        begin
            i = 0;
            while (pick(s) !== exp && i < lim) begin
                @(negedge sys_clk);
                i = i + 1;
            end
            chk(pick(s), exp);
            if (pick(s) !== exp)
                stop_test;
        end
    endtask

    task stop_test;
        begin
            $display("checked %0d n_errors %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // ============================================================
    // Scenarios
    task t_idle;
        begin
            ctl.issue(`SDCSD_CMD_HALT, 12'h000, 16'h0000, 1'b1);
            ctl.issue(`SDCSD_CMD_CLOSE, 12'h400, 16'h0000, 1'b1);
            repeat (4) @(negedge sys_clk);
            chk(pick(0) | pick(1), 16'h0000);
            ctl.gate(1'b0);
            wait_for(2, 16'h0001, 8);
            ctl.gate(1'b1);
            wait_for(2, 16'h0000, 8);
            ctl.issue(`SDCSD_CMD_MODE_LOAD, 12'h003, 16'h0000, 1'b1);
            wait_for(5, 16'h0003, 8);
            $display("test idle and mode done");
        end
    endtask

    // Open bank 0 and start a read at col with the given masks
    task open_read(input [11:0] col, input u, input l);
        begin
            ctl.masks(u, l);
            if (bank0_state !== 3'h1) begin
                ctl.issue(`SDCSD_CMD_ROW_OPEN, 12'h000, 16'h0000, 1'b1);
                wait_for(0, 16'h0001, 8);
            end
            ctl.issue(`SDCSD_CMD_FETCH, col, 16'h0000, 1'b1);
            wait_for(0, 16'h0002, 8);
        end
    endtask

    task t_read;
        begin
            open_read(12'h005, 1'b1, 1'b0);
            chk(pick(3), 16'h0005);
            wait_for(4, 16'h00ff, 4);
            wait_for(0, 16'h0001, 14);
            open_read(12'h006, 1'b0, 1'b1);
            wait_for(4, 16'hff00, 4);
            ctl.issue(`SDCSD_CMD_HALT, 12'h000, 16'h0000, 1'b1);
            wait_for(0, 16'h0001, 6);
            open_read(12'h005, 1'b0, 1'b0);
            ctl.issue(`SDCSD_CMD_FETCH, 12'h010, 16'h0000, 1'b1);
            wait_for(3, 16'h0010, 6);
            chk(pick(0), 16'h0002);
            wait_for(0, 16'h0001, 14);
            $display("test read done");
        end
    endtask

    task t_write;
        begin
            wr_ready = 1'b0;
            open_read(12'h005, 1'b1, 1'b0);
            ctl.issue(`SDCSD_CMD_STORE, 12'h007, 16'habcd, 1'b1);
            wait_for(0, 16'h0003, 6);
            wait_for(6, 16'h0032, 4);
            chk(pick(3), 16'h0007);
            wait_for(0, 16'h0001, 16);
            wr_ready = 1'b1;
            wait_for(7, 16'h0000, 40);
            ctl.masks(1'b0, 1'b0);
            $display("test write done");
        end
    endtask

    task t_close;
        begin
            ctl.issue(`SDCSD_CMD_ROW_OPEN, 12'h800, 16'h0000, 1'b1);
            wait_for(1, 16'h0001, 8);
            open_read(12'h005, 1'b0, 1'b0);
            // Read word is column xor last drained word (0032 from the write test)
            @(negedge sys_clk);
            chk(dq_out, 16'h0537);
            ctl.issue(`SDCSD_CMD_CLOSE, 12'h000, 16'h0000, 1'b1);
            wait_for(0, 16'h0004, 6);
            chk(pick(1), 16'h0001);
            wait_for(0, 16'h0000, 4);
            ctl.issue(`SDCSD_CMD_CLOSE, 12'h400, 16'h0000, 1'b1);
            wait_for(1, 16'h0004, 6);
            wait_for(1, 16'h0000, 4);
            open_read(12'h405, 1'b0, 1'b0);
            wait_for(0, 16'h0004, 14);
            wait_for(0, 16'h0000, 4);
            $display("test close done");
        end
    endtask

    task t_power;
        begin
            ctl.issue(`SDCSD_CMD_ROW_OPEN, 12'h000, 16'h0000, 1'b1);
            wait_for(0, 16'h0001, 8);
            ctl.gate(1'b0);
            wait_for(2, 16'h0003, 8);
            ctl.issue(`SDCSD_CMD_CLOSE, 12'h400, 16'h0000, 1'b0);
            repeat (4) @(negedge sys_clk);
            chk(pick(0), 16'h0001);
            ctl.gate(1'b1);
            wait_for(2, 16'h0000, 8);
            ctl.issue(`SDCSD_CMD_CLOSE, 12'h400, 16'h0000, 1'b1);
            wait_for(0, 16'h0000, 8);
            ctl.issue(`SDCSD_CMD_REFRESH, 12'h000, 16'h0000, 1'b0);
            wait_for(2, 16'h0002, 8);
            ctl.gate(1'b1);
            wait_for(2, 16'h0000, 8);
            $display("test power done");
        end
    endtask

    // ============================================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        wr_ready = 1'b1;
        n_errors = 0;
        checked = 0;
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        chk(pick(5), 16'h0000);
        t_idle;
        t_read;
        t_write;
        t_close;
        t_power;
        stop_test;
    end
endmodule

/* verif/sdcsd_ctrl_model.sv */
// Behavioural memory controller driving the device's command pins.
// Assumes the bench calls its tasks; pins change at falling edges only.
`timescale 1ns/1ps
module sdcsd_ctrl_model (
    input  wire        sys_clk,
    output reg         clk_gate,
    output reg         chip_sel_b,
    output reg         row_strobe_b,
    output reg         col_strobe_b,
    output reg         write_b,
    output reg         lower_lane_mask,
    output reg         upper_lane_mask,
    output reg  [11:0] addr,
    output reg  [15:0] dq_in
);
    // ============================================================
    // Quiet pins from time zero
    initial begin
        clk_gate = 1'b1;
        {chip_sel_b, row_strobe_b, col_strobe_b, write_b} = 4'hf;
        {upper_lane_mask, lower_lane_mask} = 2'h0;
        addr = 12'h000;
        dq_in = 16'h0000;
    end

    // One command cycle; only legal sequences are ever asked
    // Bank pick and auto-close ride in addr as the caller sets them
    task issue(input [2:0] code, input [11:0] a, input [15:0] d, input g);
        begin
            @(negedge sys_clk);
            {chip_sel_b, row_strobe_b, col_strobe_b, write_b} <= {1'b0, code};
            addr <= a;
            dq_in <= d;
            clk_gate <= g;
            @(negedge sys_clk);
            // Released lines show the inverse, never a stale copy
            {chip_sel_b, row_strobe_b, col_strobe_b, write_b} <= {1'b1, ~code};
            addr <= ~a;
            dq_in <= ~d;
        end
    endtask

    // Gate edges start and end the hold, low power and retention modes
    task gate(input g);
        begin
            @(negedge sys_clk);
            clk_gate <= g;
        end
    endtask

    // Byte masks, each for its own lane
    task masks(input u, input l);
        begin
            @(negedge sys_clk);
            {upper_lane_mask, lower_lane_mask} <= {u, l};
        end
    endtask
endmodule
